// *** hw/acio_defines.vh ***
`ifndef ACIO_DEFINES_VH
`define ACIO_DEFINES_VH
// Sample width and counts
`define ACIO_DW          12
`define ACIO_NCOMP       8
`define ACIO_NSEQ        4
`define ACIO_CIDX_W      3
`define ACIO_SEQ_W       2
// Bands
`define ACIO_BAND_NONE   2'h0
`define ACIO_BAND_LOW    2'h1
`define ACIO_BAND_MID    2'h2
`define ACIO_BAND_HIGH   2'h3
// Condition mode field: [1:0] band, [3:2] kind
`define ACIO_MODE_W      4
`define ACIO_KIND_ALWAYS 2'h0
`define ACIO_KIND_ONCE   2'h1
`define ACIO_KIND_HALW   2'h2
`define ACIO_KIND_HONCE  2'h3
// Averaging factor codes: 0 off, n gives 2^n samples, 1..6 valid
`define ACIO_AVG_W       3
`define ACIO_AVG_OFF     3'h0
`define ACIO_AVG_MAX     3'h6
`define ACIO_ACC_W       18
// Sequence depths
`define ACIO_SEQ0_DEPTH  8
`define ACIO_SEQ1_DEPTH  4
`define ACIO_SEQ2_DEPTH  4
`define ACIO_SEQ3_DEPTH  1
`endif

// *** hw/acio_top.v ***
// Summary of operation
// R01: Result at or below low is low, up to high is mid, above is high.
// R02: Each comparator decides using current result and stored previous band.
// R03: Software resets one comparator's trigger or interrupt history separately.
// R04: Comparator interrupt status is one word, independent of sequence.
// R05: Averaging factors 2, 4, 8, 16, 32 or 64 selectable.
// R06: Averaging sums successive conversions of one input into one result.
// R07: Factor zero turns averaging off; each conversion passes unaveraged.
// R08: One averaging setting applies to all sequencers.
// R09: Each pushed result is a full average; FIFO depth unchanged.
// R10: Averaging divides delivered result rate by the factor.
// R11: Per-sequence clear deasserts that sequence's interrupt; handler must clear.
// R12: Software should clear early since clears arrive late through buffers.
// R13: Each sequence has an enable letting its interrupt reach processor.
// R14: The same enable can block the sequence interrupt.
// R15: Enabling a sequence interrupt first clears its pending status.
// R16: Raw and masked status are both readable per sequence.
// R17: Trigger and interrupt selections: always, once, or hysteresis variants.
// R18: Four sequences; depths eight, four, four and one.
// R19: Masked status is raw AND enable; interrupt line follows masked.
// R20: After comparator reset, next result has no prior band.
`timescale 1ns/1ps
`include "acio_defines.vh"
module acio_top (
  // Clock and reset
  input  wire                       core_clk_in,
  input  wire                       reset_n_in,
  // Conversion results from the converter core
  input  wire                       sample_valid_in,
  input  wire [`ACIO_DW-1:0]        sample_data_in,
  input  wire [`ACIO_SEQ_W-1:0]     sample_seq_in,
  input  wire [`ACIO_CIDX_W-1:0]    sample_comp_in,
  input  wire                       sample_comp_en_in,
  input  wire                       sample_last_in,
  // Averaging setting
  input  wire [`ACIO_AVG_W-1:0]     averaging_factor_in,
  // Comparator configuration
  input  wire                       comp_cfg_wr_in,
  input  wire [`ACIO_CIDX_W-1:0]    comparator_index_in,
  input  wire [`ACIO_MODE_W-1:0]    comp_trig_mode_in,
  input  wire                       comp_trig_en_in,
  input  wire [`ACIO_MODE_W-1:0]    comp_int_mode_in,
  input  wire                       comp_int_en_in,
  input  wire [`ACIO_DW-1:0]        low_threshold_in,
  input  wire [`ACIO_DW-1:0]        high_threshold_in,
  input  wire                       comp_reset_in,
  input  wire                       reset_trigger_state_in,
  input  wire                       reset_interrupt_state_in,
  input  wire                       comp_int_clear_in,
  input  wire [`ACIO_NCOMP-1:0]     comp_int_clear_mask_in,
  // Sequence interrupt control
  input  wire                       seq_int_clear_in,
  input  wire                       seq_int_enable_in,
  input  wire                       seq_int_disable_in,
  input  wire [`ACIO_SEQ_W-1:0]     sequence_number_in,
  input  wire                       masked_status_select_in,
  // Averaged results toward the sequence FIFOs
  output reg                        result_valid_out,
  output reg  [`ACIO_DW-1:0]        result_data_out,
  output reg  [`ACIO_SEQ_W-1:0]     result_seq_out,
  // Comparator outputs
  output reg  [`ACIO_NCOMP-1:0]     comp_fault_out,
  output reg  [`ACIO_NCOMP-1:0]     comp_int_status_out,
  // Sequence interrupt state
  output reg  [`ACIO_NSEQ-1:0]      seq_raw_status_out,
  output reg  [`ACIO_NSEQ-1:0]      seq_int_enable_out,
  output reg                        seq_status_bit_out,
  output reg  [`ACIO_NSEQ-1:0]      seq_irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Hardware averaging: one accumulator shared by all sequences
  reg  [`ACIO_ACC_W-1:0]  acc_r;
  reg  [6:0]              cnt_r;
  wire [6:0]              avg_len = (7'h01 << averaging_factor_in); // R05 R08
  wire [`ACIO_ACC_W-1:0]  acc_sum = acc_r + {6'h00, sample_data_in}; // R06
  wire                    avg_done = (averaging_factor_in == `ACIO_AVG_OFF) ||
                                     (averaging_factor_in > `ACIO_AVG_MAX) ||
                                     (cnt_r == avg_len - 7'h01);
  wire [`ACIO_DW-1:0]     avg_val = (averaging_factor_in > `ACIO_AVG_MAX) ?
                                    sample_data_in :
                                    acc_sum[averaging_factor_in +: `ACIO_DW]; // R07
  // Factor changes take effect cleanly only between averages; the count restarts on a done.
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_r            <= {`ACIO_ACC_W{1'b0}};
      cnt_r            <= 7'h00;
      result_valid_out <= 1'b0;
      result_data_out  <= {`ACIO_DW{1'b0}};
      result_seq_out   <= {`ACIO_SEQ_W{1'b0}};
    end else begin
      result_valid_out <= 1'b0;
      if (sample_valid_in) begin
        if (avg_done) begin
          acc_r            <= {`ACIO_ACC_W{1'b0}};
          cnt_r            <= 7'h00;
          result_valid_out <= 1'b1; // R09 R10
          result_data_out  <= avg_val;
          result_seq_out   <= sample_seq_in;
        end else begin
          acc_r <= acc_sum;
          cnt_r <= cnt_r + 7'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Digital comparators
  reg [`ACIO_DW-1:0]     lo_r   [0:`ACIO_NCOMP-1];
  reg [`ACIO_DW-1:0]     hi_r   [0:`ACIO_NCOMP-1];
  reg [`ACIO_MODE_W-1:0] tmode_r[0:`ACIO_NCOMP-1];
  reg [`ACIO_MODE_W-1:0] imode_r[0:`ACIO_NCOMP-1];
  reg [`ACIO_NCOMP-1:0]  ten_r;
  reg [`ACIO_NCOMP-1:0]  ien_r;
  reg [1:0]              tprev_r[0:`ACIO_NCOMP-1];
  reg [1:0]              iprev_r[0:`ACIO_NCOMP-1];
  reg [`ACIO_NCOMP-1:0]  tarm_r;
  reg [`ACIO_NCOMP-1:0]  iarm_r;

  wire [`ACIO_DW-1:0] ci_lo = lo_r[sample_comp_in];
  wire [`ACIO_DW-1:0] ci_hi = hi_r[sample_comp_in];
  wire [`ACIO_DW-1:0] result_data_cmp = avg_val;
  wire [1:0] band = (result_data_cmp <= ci_lo) ? `ACIO_BAND_LOW :
                    (result_data_cmp <= ci_hi) ? `ACIO_BAND_MID :
                                                 `ACIO_BAND_HIGH; // R01
  wire cmp_go = sample_valid_in && avg_done && sample_comp_en_in;

  // Evaluate one selection; returns {fire, arm_next}
  function [1:0] acio_eval;
    input [`ACIO_MODE_W-1:0] mode;
    input [1:0]              cur;
    input [1:0]              prev;
    input                    arm;
    reg                      in_band;
    reg                      entered;
    reg                      far;
    reg                      arm_n;
    begin
      in_band = (cur == mode[1:0]);
      entered = in_band && (prev != mode[1:0]); // R20
      far     = (mode[1:0] == `ACIO_BAND_LOW) ? (cur == `ACIO_BAND_HIGH) :
                (mode[1:0] == `ACIO_BAND_HIGH) ? (cur == `ACIO_BAND_LOW) : 1'b0;
      arm_n   = arm | far;
      acio_eval = 2'b00;
      case (mode[3:2])
        `ACIO_KIND_ALWAYS: acio_eval = {in_band, arm_n};
        `ACIO_KIND_ONCE:   acio_eval = {entered, arm_n};
        `ACIO_KIND_HALW:   acio_eval = {in_band & arm, arm_n & ~(in_band & arm)};
        default:           acio_eval = {entered & arm, arm_n & ~(entered & arm)};
      endcase
    end
  endfunction

  wire [1:0] t_ev = acio_eval(tmode_r[sample_comp_in], band, tprev_r[sample_comp_in],
                              tarm_r[sample_comp_in]); // R17
  wire [1:0] i_ev = acio_eval(imode_r[sample_comp_in], band, iprev_r[sample_comp_in],
                              iarm_r[sample_comp_in]); // R17

  integer k;
  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      for (k = 0; k < `ACIO_NCOMP; k = k + 1) begin
        lo_r[k]    <= {`ACIO_DW{1'b0}};
        hi_r[k]    <= {`ACIO_DW{1'b0}};
        tmode_r[k] <= {`ACIO_MODE_W{1'b0}};
        imode_r[k] <= {`ACIO_MODE_W{1'b0}};
        tprev_r[k] <= `ACIO_BAND_NONE;
        iprev_r[k] <= `ACIO_BAND_NONE;
      end
      ten_r               <= {`ACIO_NCOMP{1'b0}};
      ien_r               <= {`ACIO_NCOMP{1'b0}};
      tarm_r              <= {`ACIO_NCOMP{1'b0}};
      iarm_r              <= {`ACIO_NCOMP{1'b0}};
      comp_fault_out      <= {`ACIO_NCOMP{1'b0}};
      comp_int_status_out <= {`ACIO_NCOMP{1'b0}};
    end else begin
      comp_fault_out <= {`ACIO_NCOMP{1'b0}};
      if (comp_int_clear_in)
        comp_int_status_out <= comp_int_status_out & ~comp_int_clear_mask_in;
      if (cmp_go) begin
        tprev_r[sample_comp_in] <= band; // R02
        iprev_r[sample_comp_in] <= band; // R02
        tarm_r[sample_comp_in]  <= t_ev[0];
        iarm_r[sample_comp_in]  <= i_ev[0];
        comp_fault_out[sample_comp_in] <= ten_r[sample_comp_in] & t_ev[1];
        // Set after the clear so a same-cycle event is kept
        if (ien_r[sample_comp_in] & i_ev[1])
          comp_int_status_out[sample_comp_in] <= 1'b1; // R04
      end
      if (comp_cfg_wr_in) begin
        lo_r[comparator_index_in]    <= low_threshold_in;
        hi_r[comparator_index_in]    <= high_threshold_in;
        tmode_r[comparator_index_in] <= comp_trig_mode_in;
        imode_r[comparator_index_in] <= comp_int_mode_in;
        ten_r[comparator_index_in]   <= comp_trig_en_in;
        ien_r[comparator_index_in]   <= comp_int_en_in;
      end
      // Reset wins over a same-cycle update so no stale band survives
      if (comp_reset_in && reset_trigger_state_in) begin
        tprev_r[comparator_index_in] <= `ACIO_BAND_NONE; // R03 R20
        tarm_r[comparator_index_in]  <= 1'b0;
      end
      if (comp_reset_in && reset_interrupt_state_in) begin
        iprev_r[comparator_index_in] <= `ACIO_BAND_NONE; // R03 R20
        iarm_r[comparator_index_in]  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence interrupts
  reg                   sample_last_r;
  wire [`ACIO_NSEQ-1:0] seq_sel = (4'h1 << sequence_number_in); // R18
  wire [`ACIO_NSEQ-1:0] seq_set = (result_valid_out && sample_last_r) ?
                                  (4'h1 << result_seq_out) : 4'h0;
  reg  [`ACIO_NSEQ-1:0] raw_nxt;
  reg  [`ACIO_NSEQ-1:0] en_nxt;

  always @* begin
    raw_nxt = seq_raw_status_out;
    en_nxt  = seq_int_enable_out;
    if (seq_int_clear_in)
      raw_nxt = raw_nxt & ~seq_sel; // R11
    if (seq_int_enable_in) begin
      raw_nxt = raw_nxt & ~seq_sel; // R15
      en_nxt  = en_nxt | seq_sel; // R13
    end
    if (seq_int_disable_in)
      en_nxt = en_nxt & ~seq_sel; // R14
    raw_nxt = raw_nxt | seq_set;
  end

  always @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sample_last_r      <= 1'b0;
      seq_raw_status_out <= {`ACIO_NSEQ{1'b0}};
      seq_int_enable_out <= {`ACIO_NSEQ{1'b0}};
      seq_irq_out        <= {`ACIO_NSEQ{1'b0}};
      seq_status_bit_out <= 1'b0;
    end else begin
      if (sample_valid_in && avg_done)
        sample_last_r <= sample_last_in;
      seq_raw_status_out <= raw_nxt;
      seq_int_enable_out <= en_nxt;
      seq_irq_out        <= raw_nxt & en_nxt; // R19
      seq_status_bit_out <= masked_status_select_in ?
                            raw_nxt[sequence_number_in] & en_nxt[sequence_number_in] :
                            raw_nxt[sequence_number_in]; // R16
    end
  end

endmodule

// *** sim/acio_properties.sv ***
`timescale 1ns/1ps
`include "acio_defines.vh"
module acio_properties (
  // Clock and reset
  input wire                    core_clk_in,
  input wire                    reset_n_in,
  // Watched inputs
  input wire                    sample_valid_in,
  input wire [`ACIO_DW-1:0]     sample_data_in,
  input wire [`ACIO_AVG_W-1:0]  averaging_factor_in,
  input wire                    seq_int_clear_in,
  input wire                    seq_int_enable_in,
  input wire                    seq_int_disable_in,
  input wire [`ACIO_SEQ_W-1:0]  sequence_number_in,
  // Watched outputs
  input wire                    result_valid_out,
  input wire [`ACIO_DW-1:0]     result_data_out,
  input wire [`ACIO_NCOMP-1:0]  comp_fault_out,
  input wire [`ACIO_NSEQ-1:0]   seq_raw_status_out,
  input wire [`ACIO_NSEQ-1:0]   seq_int_enable_out,
  input wire [`ACIO_NSEQ-1:0]   seq_irq_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_avg_off_pass: assert property (averaging_factor_in == 3'h0 && sample_valid_in |=>
    result_valid_out && result_data_out == $past(sample_data_in)) else $error("bypass lost");
  a_result_has_cause: assert property (result_valid_out |-> $past(sample_valid_in))
    else $error("result without sample");
  a_fault_with_result: assert property (|comp_fault_out |-> result_valid_out)
    else $error("fault without result");
  a_irq_is_masked: assert property (
    seq_irq_out == (seq_raw_status_out & seq_int_enable_out))
    else $error("irq not raw and enable");
  a_seq_clear_wins: assert property (
    (seq_int_clear_in || seq_int_enable_in) && !result_valid_out
    |=> !seq_raw_status_out[$past(sequence_number_in)]) else $error("status not cleared");
  a_enable_sets: assert property (seq_int_enable_in && !seq_int_disable_in
    |=> seq_int_enable_out[$past(sequence_number_in)]) else $error("enable not set");
  a_disable_blocks: assert property (seq_int_disable_in && !seq_int_enable_in
    |=> !seq_int_enable_out[$past(sequence_number_in)]) else $error("enable not dropped");
  a_raw_sticky: assert property (!seq_int_clear_in && !seq_int_enable_in |=>
    (seq_raw_status_out & $past(seq_raw_status_out)) == $past(seq_raw_status_out))
    else $error("raw status lost");
  a_raw_has_cause: assert property (|(seq_raw_status_out & ~$past(seq_raw_status_out))
    |-> $past(result_valid_out)) else $error("raw set without result");
endmodule

bind acio_top acio_properties u_props (.core_clk_in, .reset_n_in, .sample_valid_in,
  .sample_data_in, .averaging_factor_in, .seq_int_clear_in, .seq_int_enable_in,
  .seq_int_disable_in, .sequence_number_in, .result_valid_out, .result_data_out,
  .comp_fault_out, .seq_raw_status_out, .seq_int_enable_out, .seq_irq_out);

// *** sim/tb_acio_top.sv ***
`timescale 1ns/1ps
`include "acio_defines.vh"
module tb_acio_top;
  // Stimulus
  reg                    core_clk_in = 1'b0;
  reg                    reset_n_in, sample_valid_in, sample_comp_en_in, sample_last_in;
  reg                    comp_cfg_wr_in, comp_trig_en_in, comp_int_en_in, comp_reset_in;
  reg                    reset_trigger_state_in, reset_interrupt_state_in, comp_int_clear_in;
  reg                    seq_int_clear_in, seq_int_enable_in, seq_int_disable_in;
  reg                    masked_status_select_in;
  reg [`ACIO_DW-1:0]     sample_data_in, low_threshold_in, high_threshold_in;
  reg [`ACIO_SEQ_W-1:0]  sample_seq_in, sequence_number_in;
  reg [`ACIO_CIDX_W-1:0] sample_comp_in, comparator_index_in;
  reg [`ACIO_AVG_W-1:0]  averaging_factor_in;
  reg [`ACIO_MODE_W-1:0] comp_trig_mode_in, comp_int_mode_in;
  reg [`ACIO_NCOMP-1:0]  comp_int_clear_mask_in;
  // Observed
  wire                   result_valid_out, seq_status_bit_out;
  wire [`ACIO_DW-1:0]    result_data_out;
  wire [`ACIO_SEQ_W-1:0] result_seq_out;
  wire [`ACIO_NCOMP-1:0] comp_fault_out, comp_int_status_out;
  wire [`ACIO_NSEQ-1:0]  seq_raw_status_out, seq_int_enable_out, seq_irq_out;
  integer                errors = 0, check_count = 0, res_cnt = 0;

  acio_top dut (.core_clk_in, .reset_n_in, .sample_valid_in, .sample_data_in, .sample_seq_in,
    .sample_comp_in, .sample_comp_en_in, .sample_last_in, .averaging_factor_in, .comp_cfg_wr_in,
    .comparator_index_in, .comp_trig_mode_in, .comp_trig_en_in, .comp_int_mode_in,
    .comp_int_en_in, .low_threshold_in, .high_threshold_in, .comp_reset_in,
    .reset_trigger_state_in, .reset_interrupt_state_in, .comp_int_clear_in,
    .comp_int_clear_mask_in, .seq_int_clear_in, .seq_int_enable_in, .seq_int_disable_in,
    .sequence_number_in, .masked_status_select_in, .result_valid_out, .result_data_out,
    .result_seq_out, .comp_fault_out, .comp_int_status_out, .seq_raw_status_out,
    .seq_int_enable_out, .seq_status_bit_out, .seq_irq_out);

  always #2.5 core_clk_in = ~core_clk_in;
  // Counts results so early averages show up as a surplus
  always @(posedge core_clk_in) if (result_valid_out === 1'b1) res_cnt <= res_cnt + 1;
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp, input string what);
    check_count = check_count + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("mismatch at %0t: %0s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task send(input [11:0] d, input [1:0] s, input last);
    @(posedge core_clk_in);
    {sample_valid_in, sample_data_in, sample_seq_in, sample_last_in} <= {1'b1, d, s, last};
    @(posedge core_clk_in);
    sample_valid_in <= 1'b0;
    #1;
  endtask
  // Bits: comparator reset, comparator clear, disable, enable, clear
  task pulse(input [4:0] k, input [1:0] s);
    @(posedge core_clk_in);
    {comp_reset_in, comp_int_clear_in, seq_int_disable_in,
     seq_int_enable_in, seq_int_clear_in} <= k;
    sequence_number_in <= s;
    @(posedge core_clk_in);
    {comp_reset_in, comp_int_clear_in, seq_int_disable_in,
     seq_int_enable_in, seq_int_clear_in} <= 5'h00;
    #1;
  endtask
  task cfg(input [3:0] m);
    @(posedge core_clk_in);
    {comp_cfg_wr_in, comp_trig_mode_in, comp_int_mode_in} <= {1'b1, m, m};
    @(posedge core_clk_in);
    comp_cfg_wr_in <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task avg_test;
    integer n, k, base;
    reg [17:0] sum;
    for (n = 0; n < 7; n = n + 1) begin
      sum = 18'h0;
      @(posedge core_clk_in);
      averaging_factor_in <= n[2:0];
      // Baseline taken after the previous result pulse has been counted
      #1;
      base = res_cnt;
      for (k = 0; k < (1 << n); k = k + 1) begin
        sum = sum + 12'h0f0 + 7 * k;
        send(12'h0f0 + 7 * k, n[1:0], k == (1 << n) - 1);
      end
      chk(result_valid_out, 1, "average out");
      chk(result_data_out, sum >> n, "average value");
      chk(result_seq_out, n[1:0], "average seq");
      chk(res_cnt - base, 0, "early results");
    end
    @(posedge core_clk_in);
    averaging_factor_in <= 3'h7;
    send(12'h5a5, 2'h3, 1'b0);
    chk(result_data_out, 12'h5a5, "factor above range");
    @(posedge core_clk_in);
    averaging_factor_in <= 3'h0;
    $display("averaging test done");
  endtask
  task band_test;
    integer b, i;
    reg [11:0] v;
    for (b = 1; b < 4; b = b + 1)
      for (i = 0; i < 4; i = i + 1) begin
        v = (i < 2) ? 12'd100 + i : 12'd198 + i;
        cfg({2'h0, b[1:0]});
        pulse(5'h08, 0);
        send(v, 0, 0);
        chk(comp_fault_out[0], ((v <= 100) ? 1 : (v <= 200) ? 2 : 3) == b, "fault band");
        chk(comp_int_status_out[0], ((v <= 100) ? 1 : (v <= 200) ? 2 : 3) == b, "int band");
      end
    $display("band test done");
  endtask
  task once_test;
    cfg({`ACIO_KIND_ONCE, `ACIO_BAND_HIGH});
    pulse(5'h18, 0);
    send(12'd250, 0, 0);
    chk(comp_int_status_out[0], 1, "first entry");
    pulse(5'h08, 0);
    send(12'd251, 0, 0);
    chk(comp_fault_out[0], 0, "no refire");
    chk(comp_int_status_out[0], 0, "no refire int");
    pulse(5'h10, 0);
    send(12'd252, 0, 0);
    chk(comp_fault_out[0], 1, "fresh after reset");
    pulse(5'h08, 0);
    @(posedge core_clk_in);
    reset_interrupt_state_in <= 1'b0;
    pulse(5'h10, 0);
    send(12'd253, 0, 0);
    chk(comp_fault_out[0], 1, "trigger history reset");
    chk(comp_int_status_out[0], 0, "int history kept");
    @(posedge core_clk_in);
    reset_interrupt_state_in <= 1'b1;
    $display("once test done");
  endtask
  task hyst_test;
    integer h;
    for (h = 2; h < 4; h = h + 1) begin
      @(posedge core_clk_in);
      comp_int_en_in <= h[0];
      cfg({h[1:0], `ACIO_BAND_HIGH});
      pulse(5'h18, 0);
      send(12'd250, 0, 0);
      chk(comp_fault_out[0], 0, "unarmed high");
      send(12'd50, 0, 0);
      chk(comp_fault_out[0], 0, "arming low");
      send(12'd250, 0, 0);
      chk(comp_fault_out[0], 1, "armed high");
      chk(comp_int_status_out[0], h[0], "int selection gate");
      send(12'd251, 0, 0);
      chk(comp_fault_out[0], 0, "disarmed");
    end
    $display("hysteresis test done");
  endtask
  task seq_irq_test;
    pulse(5'h01, 2);
    chk(seq_raw_status_out[2], 0, "raw idle");
    send(12'h123, 2, 1);
    repeat (3) @(posedge core_clk_in);
    #1;
    chk(seq_raw_status_out[2], 1, "raw set");
    chk(seq_irq_out, 0, "blocked");
    chk(seq_status_bit_out, 1, "raw view");
    @(posedge core_clk_in);
    masked_status_select_in <= 1'b1;
    @(posedge core_clk_in);
    #1;
    chk(seq_status_bit_out, 0, "masked hides");
    pulse(5'h02, 2);
    chk(seq_raw_status_out[2], 0, "stale cleared");
    chk(seq_int_enable_out, 4'h4, "enabled");
    send(12'h124, 2, 1);
    repeat (2) @(posedge core_clk_in);
    #1;
    chk(seq_irq_out, 4'h4, "irq up");
    chk(seq_status_bit_out, 1, "masked view");
    pulse(5'h01, 2);
    chk(seq_irq_out, 0, "irq cleared");
    pulse(5'h04, 2);
    chk(seq_int_enable_out, 0, "disabled");
    $display("sequence interrupt test done");
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n_in, sample_valid_in, sample_last_in, comp_cfg_wr_in, comp_reset_in} = 0;
    {comp_int_clear_in, seq_int_clear_in, seq_int_enable_in, seq_int_disable_in} = 0;
    {masked_status_select_in, sample_data_in, sample_seq_in, sequence_number_in} = 0;
    {sample_comp_in, comparator_index_in, averaging_factor_in} = 0;
    {comp_trig_mode_in, comp_int_mode_in} = 0;
    {sample_comp_en_in, comp_trig_en_in, comp_int_en_in} = 3'h7;
    {reset_trigger_state_in, reset_interrupt_state_in} = 2'h3;
    {low_threshold_in, high_threshold_in, comp_int_clear_mask_in} = {12'd100, 12'd200, 8'hff};
    repeat (10) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    avg_test;
    band_test;
    once_test;
    hyst_test;
    seq_irq_test;
    end_sim;
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk_in);
    errors = errors + 1;
    end_sim;
  end
endmodule
